/* File: hw/c16_regs.svh */
`ifndef C16_REGS_SVH
`define C16_REGS_SVH

// ****************************************
// Frame constants
// ****************************************
`define C16_CLASS_ID    8'h56
`define C16_CMD_ID      8'h01
`define C16_EXT_FIRST   8'hf1
`define C16_POLY        16'h1021
`define C16_INIT        16'h1d0f

// ****************************************
// Length limits and buffer sizes
// ****************************************
`define C16_MIN_LEN     7'd6
`define C16_MIN_LEN_EXT 7'd7
`define C16_MAX_LEN     7'd64
`define C16_FIFO_DEPTH  8
`define C16_FIFO_AW     3
`define C16_FIFO_W      9

`endif

/* File: hw/c16_pkg.sv */
`include "c16_regs.svh"

package c16_pkg;

   // ****************************************
   // Types
   // ****************************************
   typedef logic [7:0] c16_byte_t;

   typedef enum logic [1:0] {
      RX_RECV  = 2'b01,
      RX_DRAIN = 2'b10
   } c16_rx_e;

   typedef enum logic [5:0] {
      TX_IDLE = 6'b000001,
      TX_HDR0 = 6'b000010,
      TX_HDR1 = 6'b000100,
      TX_BODY = 6'b001000,
      TX_CRCH = 6'b010000,
      TX_CRCL = 6'b100000
   } c16_tx_e;

   // One byte into the checksum, msb first
   function automatic logic [15:0] c16_crc_step(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      logic        fb;
      c = crc;
      for (int i = 7; i >= 0; i--) begin
         fb = c[15] ^ b[i];
         c  = {c[14:0], 1'b0};
         if (fb) begin
            c = c ^ `C16_POLY;
         end
      end
      return c;
   endfunction

endpackage

/* File: hw/c16_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface c16_link_if;
   logic [7:0] req_data;
   logic       req_valid;
   logic       req_last;
   logic       req_ready;
   logic [7:0] rsp_data;
   logic       rsp_valid;
   logic       rsp_last;
   logic       rsp_ready;

   modport device (
      input  req_data, req_valid, req_last, rsp_ready,
      output req_ready, rsp_data, rsp_valid, rsp_last
   );
   modport node (
      output req_data, req_valid, req_last, rsp_ready,
      input  req_ready, rsp_data, rsp_valid, rsp_last
   );
endinterface

`default_nettype wire

/* File: hw/c16_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module c16_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output var  logic         in_ready,
   output var  logic [W-1:0] out_data,
   output var  logic         out_valid,
   input  wire logic         out_ready
);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0]   cnt;
   logic [AW:0]   next_cnt;
   logic          push;
   logic          pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_valid = (cnt != '0);
   assign out_data  = mem[rp];
   assign next_cnt  = cnt + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clk) begin
      if (reset) begin
         wp       <= '0;
         rp       <= '0;
         cnt      <= '0;
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
         cnt      <= next_cnt;
         // Registered full flag keeps the source's ready free of logic
         in_ready <= (next_cnt != (AW+1)'(DEPTH));
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end
endmodule

`default_nettype wire

/* File: hw/c16_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "c16_regs.svh"

// Summary of operation
// - Frame starts with class 0x56, command 0x01
// - Then inner class, one or two bytes
// - Then one inner command byte
// - Then the inner payload bytes
// - Checksum: poly 0x1021, start 0x1d0f, unreflected
// - Checksum spans header through last payload
// - Checksum sent high byte then low
// - Wrapped request gets wrapped response
// - Plain request gets plain response
// - Wrapped form of every class accepted except class 0x56 itself (nested frames dropped)
// - Sender checks destination support before wrapping
// - Checksum layer is always outermost
// - Node info frame always lists class
// - Secure supported list never lists class
// - Wrapping applied last, instead of security
module c16_device (
   input  wire logic       clk,
   input  wire logic       reset,
   c16_link_if.device      link,
   output var  logic [7:0] cmd_data,
   output var  logic       cmd_valid,
   output var  logic       cmd_last,
   input  wire logic       cmd_ready,
   output var  logic       cmd_wrapped,
   output var  logic       rx_error,
   input  wire logic [7:0] resp_data,
   input  wire logic       resp_valid,
   input  wire logic       resp_last,
   output var  logic       resp_ready,
   output var  logic       adv_node_info,
   output var  logic       adv_secure_list
);
   // ****************************************
   // Receive side
   // ****************************************
   c16_pkg::c16_rx_e rx_state;
   c16_pkg::c16_rx_e next_rx_state;
   logic [7:0]  mem [64];
   logic [6:0]  cnt;
   logic [6:0]  len;
   logic [15:0] crc;
   logic [15:0] crc_p1;
   logic [7:0]  prev_byte;
   logic        first_cls, hdr_ok, ext_cls, nested, overflow;
   logic        take, is_wrapped, frame_bad, cmd_load;
   logic [6:0]  rd, rd_end;

   assign take     = link.req_valid && link.req_ready;
   assign len      = cnt + 7'd1;
   assign cmd_load = !cmd_valid || cmd_ready;

   assign is_wrapped = hdr_ok || (cnt == 7'd1 && first_cls && link.req_data == `C16_CMD_ID);

   always_comb begin
      frame_bad = 1'b0;
      if (is_wrapped) begin
         if (len < (ext_cls ? `C16_MIN_LEN_EXT : `C16_MIN_LEN)) begin
            frame_bad = 1'b1;
         end
         // covers all bytes before the checksum
         if ({prev_byte, link.req_data} != crc_p1) begin
            frame_bad = 1'b1;
         end
         if (nested) begin
            frame_bad = 1'b1;
         end
      end
      if (overflow || cnt == `C16_MAX_LEN) begin
         frame_bad = 1'b1;
      end
   end

   always_comb begin
      next_rx_state = rx_state;
      unique case (rx_state)
         c16_pkg::RX_RECV: begin
            if (take && link.req_last && !frame_bad) begin
               next_rx_state = c16_pkg::RX_DRAIN;
            end
         end
         c16_pkg::RX_DRAIN: begin
            if (cmd_load && rd == rd_end) begin
               next_rx_state = c16_pkg::RX_RECV;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_state       <= c16_pkg::RX_RECV;
         link.req_ready <= 1'b0;
      end else begin
         rx_state       <= next_rx_state;
         // Ready drops while a frame drains so the sender is held off
         link.req_ready <= (next_rx_state == c16_pkg::RX_RECV);
      end
   end

   // Frame collection and header flags
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt       <= '0;
         first_cls <= 1'b0;
         hdr_ok    <= 1'b0;
         ext_cls   <= 1'b0;
         nested    <= 1'b0;
         overflow  <= 1'b0;
         prev_byte <= '0;
      end else if (take) begin
         prev_byte <= link.req_data;
         if (link.req_last) begin
            cnt      <= '0;
            hdr_ok   <= 1'b0;
            overflow <= 1'b0;
         end else if (cnt == `C16_MAX_LEN) begin
            overflow <= 1'b1;
         end else begin
            cnt <= cnt + 7'd1;
         end
         if (cnt == 7'd0) begin
            first_cls <= (link.req_data == `C16_CLASS_ID);
         end
         if (cnt == 7'd1) begin
            hdr_ok <= first_cls && (link.req_data == `C16_CMD_ID);
         end
         if (cnt == 7'd2) begin
            ext_cls <= (link.req_data >= `C16_EXT_FIRST);
            nested  <= (link.req_data == `C16_CLASS_ID);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (take && cnt != `C16_MAX_LEN) begin
         mem[cnt[5:0]] <= link.req_data;
      end
   end

   // running checksum with one byte of history
   always_ff @(posedge clk) begin
      if (reset) begin
         crc    <= `C16_INIT;
         crc_p1 <= `C16_INIT;
      end else if (take) begin
         if (link.req_last) begin
            crc    <= `C16_INIT;
            crc_p1 <= `C16_INIT;
         end else begin
            crc    <= c16_pkg::c16_crc_step(crc, link.req_data);
            crc_p1 <= crc;
         end
      end
   end

   // good frames release the inner command, bad ones vanish
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_error    <= 1'b0;
         cmd_wrapped <= 1'b0;
         rd          <= '0;
         rd_end      <= '0;
      end else begin
         rx_error <= take && link.req_last && frame_bad;
         if (take && link.req_last && !frame_bad) begin
            cmd_wrapped <= is_wrapped;
            // inner class, command and payload pass through
            rd          <= is_wrapped ? 7'd2 : 7'd0;
            rd_end      <= is_wrapped ? len - 7'd2 : len;
         end else if (rx_state == c16_pkg::RX_DRAIN && cmd_load && rd != rd_end) begin
            rd <= rd + 7'd1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_valid <= 1'b0;
         cmd_data  <= '0;
         cmd_last  <= 1'b0;
      end else if (cmd_load) begin
         cmd_valid <= 1'b0;
         if (rx_state == c16_pkg::RX_DRAIN && rd != rd_end) begin
            cmd_valid <= 1'b1;
            cmd_data  <= mem[rd[5:0]];
            cmd_last  <= (rd == rd_end - 7'd1);
         end
      end
   end

   // ****************************************
   // Transmit side
   // ****************************************
   c16_pkg::c16_tx_e tx_state;
   logic [8:0]  f_data;
   logic        f_valid, f_ready, out_load, tx_wrap;
   logic [15:0] tcrc;

   assign out_load = !link.rsp_valid || link.rsp_ready;
   assign f_ready  = (tx_state == c16_pkg::TX_BODY) && out_load;

   c16_fifo #(
      .W     (`C16_FIFO_W),
      .DEPTH (`C16_FIFO_DEPTH),
      .AW    (`C16_FIFO_AW)
   ) u_resp_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_data   ({resp_last, resp_data}),
      .in_valid  (resp_valid),
      .in_ready  (resp_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_ready)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_state       <= c16_pkg::TX_IDLE;
         tx_wrap        <= 1'b0;
         tcrc           <= `C16_INIT;
         link.rsp_valid <= 1'b0;
         link.rsp_data  <= '0;
         link.rsp_last  <= 1'b0;
      end else if (out_load) begin
         link.rsp_valid <= 1'b0;
         link.rsp_last  <= 1'b0;
         unique case (tx_state)
            c16_pkg::TX_IDLE: begin
               tcrc <= `C16_INIT;
               if (f_valid) begin
                  // response follows the last request's form
                  tx_wrap  <= cmd_wrapped;
                  tx_state <= cmd_wrapped ? c16_pkg::TX_HDR0 : c16_pkg::TX_BODY;
               end
            end
            c16_pkg::TX_HDR0: begin
               link.rsp_valid <= 1'b1;
               link.rsp_data  <= `C16_CLASS_ID;
               tcrc           <= c16_pkg::c16_crc_step(tcrc, `C16_CLASS_ID);
               tx_state       <= c16_pkg::TX_HDR1;
            end
            c16_pkg::TX_HDR1: begin
               link.rsp_valid <= 1'b1;
               link.rsp_data  <= `C16_CMD_ID;
               tcrc           <= c16_pkg::c16_crc_step(tcrc, `C16_CMD_ID);
               tx_state       <= c16_pkg::TX_BODY;
            end
            c16_pkg::TX_BODY: begin
               if (f_valid) begin
                  link.rsp_valid <= 1'b1;
                  link.rsp_data  <= f_data[7:0];
                  link.rsp_last  <= f_data[8] && !tx_wrap;
                  tcrc           <= c16_pkg::c16_crc_step(tcrc, f_data[7:0]);
                  if (f_data[8]) begin
                     tx_state <= tx_wrap ? c16_pkg::TX_CRCH : c16_pkg::TX_IDLE;
                  end
               end
            end
            c16_pkg::TX_CRCH: begin
               link.rsp_valid <= 1'b1;
               link.rsp_data  <= tcrc[15:8];
               tx_state       <= c16_pkg::TX_CRCL;
            end
            c16_pkg::TX_CRCL: begin
               link.rsp_valid <= 1'b1;
               link.rsp_data  <= tcrc[7:0];
               link.rsp_last  <= 1'b1;
               tx_state       <= c16_pkg::TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      adv_node_info   <= !reset;
      adv_secure_list <= 1'b0;
   end
endmodule

`default_nettype wire

/* File: hw/c16_node.sv */
`timescale 1ns/1ps
`default_nettype none
`include "c16_regs.svh"

module c16_node (
   input  wire logic       clk,
   input  wire logic       reset,
   c16_link_if.node        link,
   input  wire logic       dest_supports,
   input  wire logic       want_wrap,
   input  wire logic [7:0] src_data,
   input  wire logic       src_valid,
   input  wire logic       src_last,
   output var  logic       src_ready,
   output var  logic [7:0] rsp_data,
   output var  logic       rsp_valid,
   output var  logic       rsp_last,
   output var  logic       rsp_wrapped,
   output var  logic       rsp_crc_bad
);
   // ****************************************
   // Transmit side
   // ****************************************
   c16_pkg::c16_tx_e tx_state;
   logic [8:0]  f_data;
   logic        f_valid, f_ready, out_load, tx_wrap;
   logic [15:0] tcrc;

   assign out_load = !link.req_valid || link.req_ready;
   assign f_ready  = (tx_state == c16_pkg::TX_BODY) && out_load;

   c16_fifo #(
      .W     (`C16_FIFO_W),
      .DEPTH (`C16_FIFO_DEPTH),
      .AW    (`C16_FIFO_AW)
   ) u_src_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_data   ({src_last, src_data}),
      .in_valid  (src_valid),
      .in_ready  (src_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_ready)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_state       <= c16_pkg::TX_IDLE;
         tx_wrap        <= 1'b0;
         tcrc           <= `C16_INIT;
         link.req_valid <= 1'b0;
         link.req_data  <= '0;
         link.req_last  <= 1'b0;
      end else if (out_load) begin
         link.req_valid <= 1'b0;
         link.req_last  <= 1'b0;
         unique case (tx_state)
            c16_pkg::TX_IDLE: begin
               tcrc <= `C16_INIT;
               if (f_valid) begin
                  // wrap only toward a destination that supports it
                  tx_wrap  <= want_wrap && dest_supports;
                  tx_state <= (want_wrap && dest_supports) ? c16_pkg::TX_HDR0
                                                           : c16_pkg::TX_BODY;
               end
            end
            c16_pkg::TX_HDR0: begin
               link.req_valid <= 1'b1;
               link.req_data  <= `C16_CLASS_ID;
               tcrc           <= c16_pkg::c16_crc_step(tcrc, `C16_CLASS_ID);
               tx_state       <= c16_pkg::TX_HDR1;
            end
            c16_pkg::TX_HDR1: begin
               link.req_valid <= 1'b1;
               link.req_data  <= `C16_CMD_ID;
               tcrc           <= c16_pkg::c16_crc_step(tcrc, `C16_CMD_ID);
               tx_state       <= c16_pkg::TX_BODY;
            end
            c16_pkg::TX_BODY: begin
               if (f_valid) begin
                  link.req_valid <= 1'b1;
                  link.req_data  <= f_data[7:0];
                  link.req_last  <= f_data[8] && !tx_wrap;
                  tcrc           <= c16_pkg::c16_crc_step(tcrc, f_data[7:0]);
                  if (f_data[8]) begin
                     tx_state <= tx_wrap ? c16_pkg::TX_CRCH : c16_pkg::TX_IDLE;
                  end
               end
            end
            c16_pkg::TX_CRCH: begin
               link.req_valid <= 1'b1;
               link.req_data  <= tcrc[15:8];
               tx_state       <= c16_pkg::TX_CRCL;
            end
            c16_pkg::TX_CRCL: begin
               link.req_valid <= 1'b1;
               link.req_data  <= tcrc[7:0];
               link.req_last  <= 1'b1;
               tx_state       <= c16_pkg::TX_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Receive side
   // ****************************************
   logic [6:0]  cnt;
   logic [15:0] crc;
   logic [15:0] crc_p1;
   logic [7:0]  prev_byte;
   logic        first_cls, hdr_ok, take, wrapped_now;

   // No stall toward the user: frames are shown raw as they arrive
   assign take        = link.rsp_valid && link.rsp_ready;
   assign wrapped_now = hdr_ok || (cnt == 7'd1 && first_cls && link.rsp_data == `C16_CMD_ID);

   always_ff @(posedge clk) begin
      if (reset) begin
         link.rsp_ready <= 1'b0;
         cnt            <= '0;
         first_cls      <= 1'b0;
         hdr_ok         <= 1'b0;
         prev_byte      <= '0;
         crc            <= `C16_INIT;
         crc_p1         <= `C16_INIT;
         rsp_valid      <= 1'b0;
         rsp_data       <= '0;
         rsp_last       <= 1'b0;
         rsp_wrapped    <= 1'b0;
         rsp_crc_bad    <= 1'b0;
      end else begin
         link.rsp_ready <= 1'b1;
         rsp_valid      <= take;
         rsp_last       <= take && link.rsp_last;
         rsp_crc_bad    <= 1'b0;
         if (take) begin
            rsp_data  <= link.rsp_data;
            prev_byte <= link.rsp_data;
            if (cnt == 7'd0) begin
               first_cls <= (link.rsp_data == `C16_CLASS_ID);
            end
            if (link.rsp_last) begin
               cnt         <= '0;
               hdr_ok      <= 1'b0;
               crc         <= `C16_INIT;
               crc_p1      <= `C16_INIT;
               rsp_wrapped <= wrapped_now;
               // checksum over all bytes before the trailer
               rsp_crc_bad <= wrapped_now && (cnt < 7'd5 ||
                              {prev_byte, link.rsp_data} != crc_p1);
            end else begin
               if (cnt != `C16_MAX_LEN) begin
                  cnt <= cnt + 7'd1;
               end
               hdr_ok <= wrapped_now;
               crc    <= c16_pkg::c16_crc_step(crc, link.rsp_data);
               crc_p1 <= crc;
            end
         end
      end
   end
endmodule

`default_nettype wire

/* File: testbench/c16_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module c16_wmon (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  d,
   input  wire logic        tk,
   input  wire logic        lst,
   output var  logic [6:0]  pos,
   output var  logic [7:0]  first,
   output var  logic [7:0]  prev,
   output var  logic [15:0] c1
);
   logic [15:0] c0;

   // Own checksum step, so a slip shared with the design cannot hide
   function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction

   always_ff @(posedge clk) begin
      if (reset || (tk && lst)) begin
         pos <= 7'h00;
         c0  <= 16'h1d0f;
         c1  <= 16'h1d0f;
      end else if (tk) begin
         pos <= pos + 7'h01;
         c0  <= step(c0, d);
         c1  <= c0;
         prev <= d;
         if (pos == 7'h00) begin
            first <= d;
         end
      end
   end
endmodule

module c16_asserts (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic [7:0] req_data,
   input wire logic       req_valid,
   input wire logic       req_last,
   input wire logic       req_ready,
   input wire logic [7:0] rsp_data,
   input wire logic       rsp_valid,
   input wire logic       rsp_last,
   input wire logic       rsp_ready
);
   logic [6:0]  qpos, spos;
   logic [7:0]  qfirst, sfirst, qprev, sprev;
   logic [15:0] qc1, sc1;
   logic        lastw;
   wire logic   qtk = req_valid && req_ready;
   wire logic   stk = rsp_valid && rsp_ready;

   c16_wmon req_c16_wmon_i (.clk(clk), .reset(reset), .d(req_data), .tk(qtk), .lst(req_last),
      .pos(qpos), .first(qfirst), .prev(qprev), .c1(qc1));
   c16_wmon rsp_c16_wmon_i (.clk(clk), .reset(reset), .d(rsp_data), .tk(stk), .lst(rsp_last),
      .pos(spos), .first(sfirst), .prev(sprev), .c1(sc1));

   // Form of the latest request
   always_ff @(posedge clk) begin
      if (reset) begin
         lastw <= 1'b0;
      end else if (qtk && req_last) begin
         lastw <= (qfirst == 8'h56);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_req_wend;
      qtk && req_last && qfirst == 8'h56;
   endsequence
   sequence s_rsp_wend;
      stk && rsp_last && sfirst == 8'h56;
   endsequence

   AST_REQ_HOLD: assert property (
      req_valid && !req_ready |=> req_valid && $stable(req_data) && $stable(req_last))
      else $error("request beat not held");
   AST_REQ_HDR: assert property (
      qtk && qpos == 7'h01 && qfirst == 8'h56 |-> req_data == 8'h01)
      else $error("request wrapper command wrong");
   AST_RSP_HDR: assert property (
      stk && spos == 7'h01 && sfirst == 8'h56 |-> rsp_data == 8'h01)
      else $error("response wrapper command wrong");
   AST_REQ_NEST: assert property (
      qtk && qpos == 7'h02 && qfirst == 8'h56 |-> req_data != 8'h56)
      else $error("wrapped frame nested");
   AST_REQ_MIN: assert property (
      s_req_wend |-> qpos >= 7'h05)
      else $error("wrapped request too short");
   AST_REQ_CRC: assert property (
      s_req_wend |-> {qprev, req_data} == qc1)
      else $error("request checksum wrong");
   AST_RSP_CRC: assert property (
      s_rsp_wend |-> {sprev, rsp_data} == sc1)
      else $error("response checksum wrong");
   AST_RSP_FORM: assert property (
      stk && spos == 7'h00 |-> (rsp_data == 8'h56) == lastw)
      else $error("response form differs from request");
endmodule

`default_nettype wire

/* File: testbench/crc16_command_encapsulator_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module crc16_command_encapsulator_tb_top;
   typedef c16_pkg::c16_byte_t c16_q_t[$];

   logic       clk = 1'b0, reset = 1'b1, dest_supports = 1'b1, want_wrap = 1'b1;
   logic       cmd_ready = 1'b1, dv = 1'b0, dl = 1'b0, crc_bad = 1'b0;
   logic [7:0] dd = 8'h00, cmd_data, rsp_data;
   logic       cmd_valid, cmd_last, cmd_wrapped, resp_ready, adv_node_info, adv_secure_list;
   logic       src_ready, rsp_valid, rsp_last, rsp_wrapped, rsp_crc_bad, cmd_valid2, rx_error2;
   int         sel = 0, error_cnt = 0, n_checks = 0, stall = 0, cyc = 0;
   int         n_cmd2 = 0, n_err2 = 0, n_last = 0;
   c16_q_t     cq, rq, lq;

   always #25 clk = ~clk;

   c16_link_if c16_link_if_i ();
   // Second device faces the bench, so it can be fed broken frames
   c16_link_if bad_c16_link_if_i ();
   assign bad_c16_link_if_i.req_data = dd;
   assign bad_c16_link_if_i.req_valid = dv && sel == 2;
   assign bad_c16_link_if_i.req_last = dl;
   assign bad_c16_link_if_i.rsp_ready = 1'b1;
   wire logic rdy = (sel == 0) ? src_ready : (sel == 1) ? resp_ready : bad_c16_link_if_i.req_ready;

   c16_node c16_node_i (.clk(clk), .reset(reset), .link(c16_link_if_i),
      .dest_supports(dest_supports), .want_wrap(want_wrap), .src_data(dd),
      .src_valid(dv && sel == 0), .src_last(dl), .src_ready(src_ready), .rsp_data(rsp_data),
      .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_wrapped(rsp_wrapped),
      .rsp_crc_bad(rsp_crc_bad));
   c16_device c16_device_i (.clk(clk), .reset(reset), .link(c16_link_if_i),
      .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
      .cmd_wrapped(cmd_wrapped), .rx_error(), .resp_data(dd), .resp_valid(dv && sel == 1),
      .resp_last(dl), .resp_ready(resp_ready), .adv_node_info(adv_node_info),
      .adv_secure_list(adv_secure_list));
   c16_device bad_c16_device_i (.clk(clk), .reset(reset), .link(bad_c16_link_if_i),
      .cmd_data(), .cmd_valid(cmd_valid2), .cmd_last(), .cmd_ready(1'b1), .cmd_wrapped(),
      .rx_error(rx_error2), .resp_data(8'h00), .resp_valid(1'b0), .resp_last(1'b0),
      .resp_ready(), .adv_node_info(), .adv_secure_list());
   c16_asserts c16_asserts_i (.clk(clk), .reset(reset),
      .req_data(c16_link_if_i.req_data), .req_valid(c16_link_if_i.req_valid),
      .req_last(c16_link_if_i.req_last), .req_ready(c16_link_if_i.req_ready),
      .rsp_data(c16_link_if_i.rsp_data), .rsp_valid(c16_link_if_i.rsp_valid),
      .rsp_last(c16_link_if_i.rsp_last), .rsp_ready(c16_link_if_i.rsp_ready));

   always @(posedge clk) begin
      cyc++;
      if (cmd_valid && cmd_ready) cq.push_back(cmd_data);
      if (cmd_valid && cmd_ready && cmd_last) n_last++;
      if (rsp_valid) rq.push_back(rsp_data);
      if (rsp_valid && rsp_last) crc_bad = rsp_crc_bad;
      if (c16_link_if_i.req_valid && c16_link_if_i.req_ready) lq.push_back(c16_link_if_i.req_data);
      if (cmd_valid2) n_cmd2++;
      if (rx_error2) n_err2++;
      if (cyc == 8000) begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask

   // Long refusal frees the sink so a full buffer drains
   task automatic xfer(input int s, input c16_q_t b);
      logic r;
      sel <= s;
      for (int i = 0; i < b.size(); i++) begin
         dd <= b[i];
         dv <= 1'b1;
         dl <= (i == b.size() - 1);
         do begin
            @(negedge clk);
            r = rdy;
            @(posedge clk);
            if (!r) stall++;
            if (stall == 40) cmd_ready <= 1'b1;
         end while (!r);
      end
      dv <= 1'b0;
      @(posedge clk);
   endtask

   task automatic cmpq(input string nm, ref c16_q_t q, input c16_q_t e);
      for (int i = 0; i < 400 && q.size() < e.size(); i++) @(posedge clk);
      @(posedge clk);
      chk(nm, q.size(), e.size());
      foreach (e[i]) chk(nm, q[i], e[i]);
      q = {};
   endtask

   // ****
   // Scenarios
   // ****
   task automatic t_basic();
      xfer(0, '{8'h20, 8'h02});
      cmpq("cmd", cq, '{8'h20, 8'h02});
      chk("last", n_last, 16'h0001);
      cmpq("link", lq, '{8'h56, 8'h01, 8'h20, 8'h02, 8'h4d, 8'h26});
      chk("wrapped", cmd_wrapped, 1'b1);
      xfer(1, '{8'h20, 8'h02});
      cmpq("rsp", rq, '{8'h56, 8'h01, 8'h20, 8'h02, 8'h4d, 8'h26});
      chk("rsp_form", {rsp_wrapped, crc_bad}, 2'b10);
   endtask

   task automatic t_plain();
      dest_supports <= 1'b0;
      xfer(0, '{8'h25, 8'h01, 8'h07});
      cmpq("cmd", cq, '{8'h25, 8'h01, 8'h07});
      cmpq("link", lq, '{8'h25, 8'h01, 8'h07});
      chk("wrapped", cmd_wrapped, 1'b0);
      xfer(1, '{8'h25, 8'h03, 8'h07});
      cmpq("rsp", rq, '{8'h25, 8'h03, 8'h07});
      chk("rsp_form", rsp_wrapped, 1'b0);
   endtask

   task automatic t_ext();
      dest_supports <= 1'b1;
      xfer(0, '{8'hf1, 8'h23, 8'h05, 8'haa});
      cmpq("cmd", cq, '{8'hf1, 8'h23, 8'h05, 8'haa});
      chk("wrapped", cmd_wrapped, 1'b1);
      lq = {};
   endtask

   task automatic t_fill();
      c16_q_t b = '{8'h20, 8'h01};
      c16_q_t e = '{8'h20, 8'h02};
      for (int i = 0; i < 12; i++) b.push_back(8'(i));
      stall = 0;
      cmd_ready <= 1'b0;
      xfer(0, '{8'h20, 8'h02});
      xfer(0, b);
      chk("refused", stall >= 40, 1'b1);
      e = {e, b};
      cmpq("cmd", cq, e);
      lq = {};
   endtask

   task automatic t_bad();
      xfer(2, '{8'h56, 8'h01, 8'h20, 8'h02, 8'h4d, 8'h26});
      xfer(2, '{8'h56, 8'h01, 8'h20, 8'h02, 8'h4d, 8'h27});
      xfer(2, '{8'h56, 8'h01, 8'h20, 8'h4d, 8'h26});
      repeat (10) @(posedge clk);
      chk("decoded", n_cmd2, 16'h0002);
      chk("dropped", n_err2, 16'h0002);
   endtask

   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      chk("advert", {adv_node_info, adv_secure_list}, 2'b10);
      t_basic();
      t_plain();
      t_ext();
      t_fill();
      t_bad();
      stop_test();
   end
endmodule

`default_nettype wire
